// file: design/lrr_loader.sv
// Notes on behaviour
// - run code 0x22, address MSB first
// - acknowledge run before branching
// - reset code 0x25 triggers full reset
// - acknowledge reset before starting reset
// - reset restarts device, reloading stack
// - first byte is total packet length
// - checksum is sum of payload only
// - reply 0xCC on success, 0x33 failure
// - leading zero bytes are ignored
`timescale 1ns/100ps
`default_nettype none
module lrr_loader
	import lrr_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        SYS_RST,
	input  wire logic [7:0]  RX_BYTE,
	input  wire logic        RX_VALID,
	output logic             TX_VALID,
	output logic [7:0]       TX_BYTE,
	input  wire logic        TX_READY,
	output logic             RUN_GO,
	output logic [31:0]      RUN_ADDR,
	output logic             RESET_GO,
	output logic             PKT_OTHER
);
	lrr_state_t  state, next_state;
	logic [7:0]  packet_length_byte, next_packet_length_byte;
	logic [7:0]  payload_sum_byte, next_payload_sum_byte;
	logic [7:0]  sum, next_sum;
	logic [7:0]  cnt, next_cnt;
	logic [7:0]  cmd, next_cmd;
	logic [31:0] addr, next_addr;
	logic [7:0]  reply, next_reply;
	logic        go_run, next_go_run;
	logic        go_rst, next_go_rst;
	logic        other, next_other;

	function automatic logic [7:0] lrr_add(input logic [7:0] a, input logic [7:0] b);
		lrr_add = 8'(a + b);
	endfunction

	// the frame is judged only once complete, so a bad length still drains its bytes
	function automatic logic frame_ok(input logic [7:0] c, input logic [7:0] l,
		input logic [7:0] s, input logic [7:0] p);
		logic len_ok;
		len_ok = (c == LRR_CMD_RUN) ? (l == LRR_LEN_RUN) :
			(c == LRR_CMD_RESET) ? (l == LRR_LEN_RESET) : 1'b1;
		frame_ok = len_ok && (s == p);
	endfunction

	// on a three-byte packet the command byte is also the last one, so take it from the bus
	function automatic logic [7:0] cmd_of(input logic [7:0] c, input logic [7:0] held,
		input logic [7:0] b);
		cmd_of = (c == LRR_CMD_POS) ? b : held;
	endfunction

	always_comb begin
		next_state = state;
		next_packet_length_byte = packet_length_byte;
		next_payload_sum_byte = payload_sum_byte;
		next_sum = sum;
		next_cnt = cnt;
		next_cmd = cmd;
		next_addr = addr;
		next_reply = reply;
		next_go_run = 1'b0;
		next_go_rst = 1'b0;
		next_other = 1'b0;
		case (state)
			LRR_IDLE: begin
				if (RX_VALID && RX_BYTE != LRR_ZERO) begin
					next_packet_length_byte = RX_BYTE;
					next_sum = LRR_ZERO;
					next_cnt = LRR_HDR_BYTES;
					next_state = LRR_SUM;
				end
			end
			LRR_SUM: begin
				if (RX_VALID) begin
					next_payload_sum_byte = RX_BYTE;
					// lengths below three carry no command and are refused at once
					if (packet_length_byte < LRR_LEN_MIN) begin
						next_reply = LRR_NAK;
						next_state = LRR_REPLY;
					end else begin
						next_state = LRR_BODY;
					end
				end
			end
			LRR_BODY: begin
				if (RX_VALID) begin
					next_sum = lrr_add(sum, RX_BYTE);
					next_cnt = lrr_add(cnt, LRR_ONE);
					if (cnt == LRR_CMD_POS) begin
						next_cmd = RX_BYTE;
					end else begin
						next_addr = {addr[23:0], RX_BYTE};
					end
					if (lrr_add(cnt, LRR_ONE) == packet_length_byte) begin
						if (frame_ok(cmd_of(cnt, cmd, RX_BYTE), packet_length_byte,
							payload_sum_byte, lrr_add(sum, RX_BYTE))) begin
							next_reply = LRR_ACK;
						end else begin
							next_reply = LRR_NAK;
						end
						next_state = LRR_REPLY;
					end
				end
			end
			LRR_REPLY: begin
				if (TX_READY) begin
					// the reply byte leaves before any branch or reset is raised
					next_state = (reply == LRR_ACK) ? LRR_ACT : LRR_IDLE;
				end
			end
			LRR_ACT: begin
				next_go_run = (cmd == LRR_CMD_RUN);
				next_go_rst = (cmd == LRR_CMD_RESET);
				next_other = (cmd != LRR_CMD_RUN) && (cmd != LRR_CMD_RESET);
				next_state = LRR_IDLE;
			end
			default: next_state = LRR_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state <= LRR_IDLE;
			packet_length_byte <= LRR_ZERO;
			payload_sum_byte <= LRR_ZERO;
			sum <= LRR_ZERO;
			cnt <= LRR_ZERO;
			cmd <= LRR_ZERO;
			addr <= LRR_ADDR_RESET;
			reply <= LRR_ZERO;
			go_run <= 1'b0;
			go_rst <= 1'b0;
			other <= 1'b0;
		end else begin
			state <= next_state;
			packet_length_byte <= next_packet_length_byte;
			payload_sum_byte <= next_payload_sum_byte;
			sum <= next_sum;
			cnt <= next_cnt;
			cmd <= next_cmd;
			addr <= next_addr;
			reply <= next_reply;
			go_run <= next_go_run;
			go_rst <= next_go_rst;
			other <= next_other;
		end
	end

	assign TX_VALID = (state == LRR_REPLY);
	assign TX_BYTE = reply;
	assign RUN_GO = go_run;
	assign RUN_ADDR = addr;
	assign RESET_GO = go_rst;
	assign PKT_OTHER = other;

	a_run_after_ack: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		RUN_GO |-> $past(TX_VALID && TX_READY && TX_BYTE == LRR_ACK, 2))
		else $error("run without preceding ack");
	a_reset_after_ack: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		RESET_GO |-> $past(TX_VALID && TX_READY && TX_BYTE == LRR_ACK, 2))
		else $error("reset without preceding ack");
	a_reset_code: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		RESET_GO |-> $past(cmd) == LRR_CMD_RESET
		&& $past(packet_length_byte) == LRR_LEN_RESET)
		else $error("reset on wrong packet");
	a_run_frame: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		RUN_GO |-> $past(packet_length_byte) == LRR_LEN_RUN && $past(cmd) == LRR_CMD_RUN)
		else $error("run on wrong frame");
	a_nak_no_act: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		(TX_VALID && TX_READY && TX_BYTE == LRR_NAK)
		|-> ##1 !RUN_GO ##1 !RUN_GO && !RESET_GO && !PKT_OTHER)
		else $error("action after nak");
	a_zero_ignored: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		(state == LRR_IDLE && RX_VALID && RX_BYTE == LRR_ZERO) |=> state == LRR_IDLE)
		else $error("zero byte started packet");
	a_reply_codes: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		TX_VALID |-> (TX_BYTE == LRR_ACK || TX_BYTE == LRR_NAK))
		else $error("bad reply byte");
	a_ack_sum: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		($rose(TX_VALID) && TX_BYTE == LRR_ACK) |-> sum == payload_sum_byte)
		else $error("ack with bad sum");
	a_addr_order: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		(state == LRR_BODY && RX_VALID && cnt > LRR_CMD_POS) |=> addr[7:0] == $past(RX_BYTE)
		&& addr[15:8] == $past(addr[7:0]))
		else $error("address not shifted msb first");
	// the reply must stand unchanged until the host takes it
	a_tx_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		(TX_VALID && !TX_READY) |=> TX_VALID && $stable(TX_BYTE))
		else $error("reply dropped before taken");
	a_ack_then_act: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		(TX_VALID && TX_READY && TX_BYTE == LRR_ACK) |=> state == LRR_ACT)
		else $error("ack not followed by action step");
	a_run_single: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		RUN_GO |=> !RUN_GO)
		else $error("run pulse longer than one cycle");
	a_reset_single: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		RESET_GO |=> !RESET_GO && !RUN_GO)
		else $error("reset pulse longer than one cycle");
	a_other_after_ack: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		PKT_OTHER |-> $past(TX_VALID && TX_READY && TX_BYTE == LRR_ACK, 2))
		else $error("other command flagged without ack");
	a_short_nak: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		(state == LRR_SUM && RX_VALID && packet_length_byte < LRR_LEN_MIN)
		|=> TX_VALID && TX_BYTE == LRR_NAK)
		else $error("short packet not refused");
	a_length_first: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		(state == LRR_IDLE && RX_VALID && RX_BYTE != LRR_ZERO)
		|=> state == LRR_SUM && packet_length_byte == $past(RX_BYTE))
		else $error("first byte not taken as length");
	a_cmd_capture: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		(state == LRR_BODY && RX_VALID && cnt == LRR_CMD_POS) |=> cmd == $past(RX_BYTE))
		else $error("command byte not captured");
	a_ack_run_length: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		($rose(TX_VALID) && TX_BYTE == LRR_ACK && cmd == LRR_CMD_RUN)
		|-> packet_length_byte == LRR_LEN_RUN)
		else $error("run acked with wrong length");
endmodule
`default_nettype wire

// file: common/lrr_pkg.sv
`default_nettype none
package lrr_pkg;
	localparam logic [7:0] LRR_CMD_RUN     = 8'h22;
	localparam logic [7:0] LRR_CMD_RESET   = 8'h25;
	localparam logic [7:0] LRR_ACK         = 8'hCC;
	localparam logic [7:0] LRR_NAK         = 8'h33;
	localparam logic [7:0] LRR_ZERO        = 8'h00;
	localparam logic [7:0] LRR_LEN_RUN     = 8'h07;
	localparam logic [7:0] LRR_LEN_RESET   = 8'h03;
	localparam logic [7:0] LRR_LEN_MIN     = 8'h03;
	localparam logic [7:0] LRR_HDR_BYTES   = 8'h02;
	localparam logic [7:0] LRR_ONE         = 8'h01;
	localparam logic [7:0] LRR_CMD_POS     = 8'h02;
	localparam logic [31:0] LRR_ADDR_RESET = 32'h0000_0000;
	typedef enum logic [2:0] {
		LRR_IDLE,
		LRR_SUM,
		LRR_BODY,
		LRR_REPLY,
		LRR_ACT
	} lrr_state_t;
endpackage
`default_nettype wire

// file: test/lrr_host.sv
`timescale 1ns/100ps
`default_nettype none
module lrr_host
	import lrr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_byte,
	output logic [7:0]      rx_byte,
	output logic            rx_valid,
	output logic            tx_ready
);
	initial begin
		rx_byte = LRR_ZERO;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	// a released data line shows the inverse so a stale byte is never reused
	task automatic put(input logic [7:0] b);
		@(negedge clk);
		rx_byte = b;
		rx_valid = 1'b1;
		@(negedge clk);
		rx_valid = 1'b0;
		rx_byte = ~b;
	endtask
	task automatic send_pkt(input logic [7:0] len, input logic [7:0] cmd,
		input logic [31:0] a, input logic [7:0] bad);
		logic [7:0] sum;
		sum = (len == LRR_LEN_RUN) ? cmd + a[31:24] + a[23:16] + a[15:8] + a[7:0] : cmd;
		put(len);
		put(sum ^ bad);
		put(cmd);
		for (int i = 3; i < len; i++) put(a[8*(6-i) +: 8]);
	endtask
	task automatic take(input int stall, output logic [7:0] r, output logic ok);
		ok = 1'b0;
		for (int i = 0; i < 60 && ok !== 1'b1; i++) begin
			@(negedge clk);
			ok = tx_valid;
		end
		repeat (stall) @(negedge clk);
		tx_ready = 1'b1;
		@(posedge clk);
		r = tx_byte;
		@(negedge clk);
		tx_ready = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
	import lrr_pkg::*;
;
	logic        REF_CLK;
	logic        SYS_RST;
	logic [7:0]  RX_BYTE;
	logic        RX_VALID;
	logic        TX_VALID;
	logic [7:0]  TX_BYTE;
	logic        TX_READY;
	logic        RUN_GO;
	logic [31:0] RUN_ADDR;
	logic        RESET_GO;
	logic        PKT_OTHER;
	int          fail_count;
	int          num_checks;
	lrr_loader lrr_loader_inst(.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .RX_BYTE(RX_BYTE),
		.RX_VALID(RX_VALID), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .TX_READY(TX_READY),
		.RUN_GO(RUN_GO), .RUN_ADDR(RUN_ADDR), .RESET_GO(RESET_GO), .PKT_OTHER(PKT_OTHER));
	lrr_host lrr_host_inst(.clk(REF_CLK), .tx_valid(TX_VALID), .tx_byte(TX_BYTE),
		.rx_byte(RX_BYTE), .rx_valid(RX_VALID), .tx_ready(TX_READY));
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic xfer(input logic [7:0] len, input logic [7:0] cmd, input logic [31:0] a,
		input logic [7:0] bad, input int stall, input logic [7:0] rep, input int run,
		input int rst, input int oth);
		logic [7:0] r;
		logic       ok;
		int         n_run;
		int         n_rst;
		int         n_oth;
		n_run = 0;
		n_rst = 0;
		n_oth = 0;
		lrr_host_inst.send_pkt(len, cmd, a, bad);
		lrr_host_inst.take(stall, r, ok);
		check("reply offered", 32'h1, {31'h0, ok});
		if (ok !== 1'b1) report_and_stop();
		check("reply", {24'h0, rep}, {24'h0, r});
		repeat (4) begin
			@(negedge REF_CLK);
			if (RUN_GO === 1'b1) n_run++;
			if (RESET_GO === 1'b1) n_rst++;
			if (PKT_OTHER === 1'b1) n_oth++;
			if (RUN_GO === 1'b1) check("run address", a, RUN_ADDR);
		end
		check("run pulses", run, n_run);
		check("reset pulses", rst, n_rst);
		check("other pulses", oth, n_oth);
	endtask
	task automatic t_run;
		xfer(LRR_LEN_RUN, LRR_CMD_RUN, 32'hA1B2C3D4, 8'h00, 0, LRR_ACK, 1, 0, 0);
		xfer(LRR_LEN_RUN, LRR_CMD_RUN, 32'h80000001, 8'h00, 2, LRR_ACK, 1, 0, 0);
	endtask
	task automatic t_reset;
		lrr_host_inst.put(LRR_ZERO);
		lrr_host_inst.put(LRR_ZERO);
		xfer(LRR_LEN_RESET, LRR_CMD_RESET, 32'h0, 8'h00, 3, LRR_ACK, 0, 1, 0);
	endtask
	task automatic t_refused;
		logic [7:0] r;
		logic       ok;
		xfer(LRR_LEN_RUN, LRR_CMD_RUN, 32'h12345678, 8'h01, 1, LRR_NAK, 0, 0, 0);
		xfer(LRR_LEN_RESET, LRR_CMD_RUN, 32'h0, 8'h00, 0, LRR_NAK, 0, 0, 0);
		xfer(LRR_LEN_RUN, LRR_CMD_RESET, 32'h01020304, 8'h00, 0, LRR_NAK, 0, 0, 0);
		xfer(LRR_LEN_RESET, LRR_CMD_RESET, 32'h0, 8'h80, 0, LRR_NAK, 0, 0, 0);
		xfer(LRR_LEN_RESET, 8'h20, 32'h0, 8'h00, 0, LRR_ACK, 0, 0, 1);
		// a length below three is refused right after its checksum byte
		lrr_host_inst.put(8'h02);
		lrr_host_inst.put(8'h5A);
		lrr_host_inst.take(0, r, ok);
		check("short offered", 32'h1, {31'h0, ok});
		check("short reply", {24'h0, LRR_NAK}, {24'h0, r});
	endtask
	initial begin
		REF_CLK = 1'b0;
		forever #10 REF_CLK = ~REF_CLK;
	end
	initial begin
		fail_count = 0;
		num_checks = 0;
		SYS_RST = 1'b1;
		repeat (20) @(negedge REF_CLK);
		SYS_RST = 1'b0;
		t_run();
		t_refused();
		t_reset();
		// the system applies the requested reset, then the loader must talk again
		SYS_RST = 1'b1;
		repeat (2) @(negedge REF_CLK);
		SYS_RST = 1'b0;
		t_run();
		report_and_stop();
	end
endmodule
`default_nettype wire
